// ==== logic/relay_pkg.sv ====
`default_nettype none
package relay_pkg;
    // ***************************
    // Widths
    // ***************************
    localparam int SPW = 21;  // Setpoint, -99999..999999
    localparam int HYW = 17;  // Hysteresis half width, 0..99999
    localparam int DLW = 10;  // Delay in tenths, 0..999
    localparam int TOW = 16;  // Bus silence timeout in tenths of a second
    localparam int CW  = 23;  // Comparison width, holds setpoint +/- hysteresis
    localparam int AW  = 9;

    // ***************************
    // Register map (byte addresses)
    // ***************************
    localparam logic [4:0] A_SP1    = 5'h00;
    localparam logic [4:0] A_SP2    = 5'h04;
    localparam logic [4:0] A_HYSTERESIS_HALF_WIDTH   = 5'h08;
    localparam logic [4:0] A_CFG    = 5'h0c;
    localparam logic [4:0] A_DLY    = 5'h10;
    localparam logic [4:0] A_REMOTE = 5'h14;
    localparam logic [8:0] A_CTRL   = 9'h100;
    localparam logic [8:0] A_SILENT = 9'h104;
    localparam logic [8:0] A_STATUS = 9'h108;
    // Channel block: bits [6:5] select the channel, stride 0x20
    localparam int CH_LSB = 5;

    // Field positions
    localparam int CFG_MODE  = 0;   // [2:0]
    localparam int CFG_REACT = 3;   // [4:3]
    localparam int CFG_UNIT  = 5;   // 1 = minutes
    localparam int CFG_BEEPER_MENU  = 6;   // Beeper_menu on relay activation
    localparam int DLY_ON    = 0;   // [9:0]
    localparam int DLY_OFF   = 16;  // [25:16]
    localparam int ST_OUT    = 0;   // [3:0]
    localparam int ST_WANT   = 4;   // [7:4]
    localparam int ST_CRIT   = 8;   // [11:8]
    localparam int ST_BUZZ   = 12;
    localparam int ST_SILENT = 13;

    // Reset values
    localparam logic [SPW-1:0] RST_SP   = 21'h000000;
    localparam logic [HYW-1:0] RST_HYSTERESIS_HALF_WIDTH = 17'h00000;
    localparam logic [DLW-1:0] RST_DLY  = 10'h000;
    localparam logic [TOW-1:0] RST_TO   = 16'h0000;

    // ***************************
    // Timing
    // ***************************
    localparam int CLK_PERIOD_NS = 10;
    localparam int TICK_NS       = 100_000_000;  // 0.1 s
    localparam int TICK_CYC      = TICK_NS / CLK_PERIOD_NS;
    localparam int MIN_SCALE     = 60;           // Tenth of a minute in ticks

    typedef enum logic [2:0] {
        MODE_INACTIVE, MODE_ON, MODE_OFF, MODE_IN, MODE_OUT, MODE_REMOTE
    } mode_t;

    typedef enum logic [1:0] {REACT_HOLD, REACT_ON, REACT_OFF} react_t;
endpackage
`default_nettype wire

// ==== logic/relay_threshold_controller.sv ====
// Overview of operation
// - Signed first setpoint, hysteresis centre
// - Second setpoint used only in windows
// - Hysteresis half width, band twice it
// - Inactive mode keeps relay off
// - Normal: on above, off below band
// - Inverted: off above, on below band
// - Window inside: on within inner zone
// - Window outside: on beyond outer borders
// - Window bounds are max and min
// - Remote mode follows bus commands only
// - LED lit whenever relay closed
// - Remote states cleared at restart
// - Separate on/off delays in tenths
// - Short crossing leaves relay, restarts delay
// - Delay unit seconds or minutes
// - Critical: hold, force on, force off
// - Over range is critical in threshold modes
// - Bus silence is critical in remote
// - Force on overrides inactive mode
// - Beeper_menu on critical when enabled
// - Beeper_menu on relay activation when enabled
// - Any button silences the beeper
//
// Decided for this implementation: the register offsets and register access over APB.
`timescale 1ns/100ps
`default_nettype none
module relay_threshold_controller
    import relay_pkg::*;
#(
    parameter int NCH         = 4,         // Relay channels, 1..4
    parameter int TICK_CYCLES = TICK_CYC   // Cycles per 0.1 s
) (
    input  wire logic                  i_clk,          // System clock
    input  wire logic                  i_rst_b,        // Async reset, active low
    input  wire logic                  i_psel,         // APB select
    input  wire logic                  i_penable,      // APB enable
    input  wire logic                  i_pwrite,       // APB write
    input  wire logic [AW-1:0]         i_paddr,        // APB address
    input  wire logic [31:0]           i_pwdata,       // APB write data
    output logic [31:0]                o_prdata,       // APB read data
    output logic                       o_pready,       // APB ready
    output logic                       o_pslverr,      // APB error
    input  wire logic                  i_sample_valid, // New measurement
    input  wire logic signed [SPW-1:0] i_sample,       // Measured or peak value
    input  wire logic                  i_over_range,   // Permissible range exceeded
    input  wire logic                  i_button,       // Any front button, pin
    output logic [NCH-1:0]             o_relay,        // Relay coils
    output logic [NCH-1:0]             o_led,          // Relay LEDs
    output logic                       o_buzzer        // Acoustic signal
);
    // ***************************
    // Helpers
    // ***************************
    function automatic logic signed [CW-1:0] sx(input logic signed [SPW-1:0] v);
        return CW'(v);
    endfunction
    function automatic logic signed [CW-1:0] hx(input logic [HYW-1:0] v);
        return signed'({{(CW-HYW){1'b0}}, v});
    endfunction

    // ***************************
    // Registers
    // ***************************
    logic signed [SPW-1:0] sp1_r  [NCH];
    logic signed [SPW-1:0] sp2_r  [NCH];
    logic [HYW-1:0]        hysteresis_half_width_r [NCH];
    mode_t                 mode_r [NCH];
    react_t                react_r[NCH];
    logic [DLW-1:0]        don_r  [NCH];
    logic [DLW-1:0]        doff_r [NCH];
    logic [DLW-1:0]        cnt_r  [NCH];
    logic [NCH-1:0]        unit_r, beeper_menu_en_r, cmd_r, want_r, want_nxt;
    logic [NCH-1:0]        relay_r, out_r, out_d_r, crit;
    logic                  beeper_menu_alarm_r;
    logic [TOW-1:0]        timeout_r, sil_cnt_r;
    logic                  silent, crit_any_r, beeper_menu_r, beeper_menu_set, press;
    logic                  btn_s1_r, btn_s2_r, btn_s3_r;
    logic [23:0]           tick_cnt_r;
    logic [5:0]            min_cnt_r;
    logic                  tick, tick_min;

    // ***************************
    // APB slave
    // ***************************
    logic          setup, wr, ch_ok, glb_ok, rd_ok, err_r, remote_wr;
    logic [1:0]    ch;
    logic [4:0]    off;
    logic [31:0]   rd_val;

    assign setup  = i_psel && !i_penable;
    assign wr     = i_psel && i_penable && i_pwrite;
    assign ch     = i_paddr[CH_LSB+1:CH_LSB];
    assign off    = i_paddr[4:0];
    assign ch_ok  = !i_paddr[8] && !i_paddr[7] && (32'(ch) < NCH) && (off <= A_REMOTE) && (off[1:0] == 2'b00);
    assign glb_ok = (i_paddr == A_CTRL) || (i_paddr == A_SILENT) || (i_paddr == A_STATUS);
    assign rd_ok  = ch_ok || glb_ok;
    assign remote_wr = wr && ch_ok && (off == A_REMOTE);
    // No wait states: data is latched during setup
    assign o_pready  = i_penable;
    assign o_pslverr = i_psel && i_penable && err_r;

    always_comb begin
        rd_val = 32'h0;
        if (glb_ok) begin
            unique case (i_paddr)
                A_CTRL:   rd_val = {31'h0, beeper_menu_alarm_r};
                A_SILENT: rd_val = {16'h0, timeout_r};
                default: begin
                    rd_val[ST_OUT+:4]  = 4'(out_r);
                    rd_val[ST_WANT+:4] = 4'(want_r);
                    rd_val[ST_CRIT+:4] = 4'(crit);
                    rd_val[ST_BUZZ]    = beeper_menu_r;
                    rd_val[ST_SILENT]  = silent;
                end
            endcase
        end else if (ch_ok) begin
            unique case (off)
                A_SP1:  rd_val = 32'(sp1_r[ch]);
                A_SP2:  rd_val = 32'(sp2_r[ch]);
                A_HYSTERESIS_HALF_WIDTH: rd_val = {15'h0, hysteresis_half_width_r[ch]};
                A_CFG: begin
                    rd_val[CFG_MODE+:3]  = mode_r[ch];
                    rd_val[CFG_REACT+:2] = react_r[ch];
                    rd_val[CFG_UNIT]     = unit_r[ch];
                    rd_val[CFG_BEEPER_MENU]     = beeper_menu_en_r[ch];
                end
                A_DLY: begin
                    rd_val[DLY_ON+:DLW]  = don_r[ch];
                    rd_val[DLY_OFF+:DLW] = doff_r[ch];
                end
                default: rd_val = {31'h0, cmd_r[ch]};
            endcase
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_prdata <= 32'h0;
            err_r    <= 1'b0;
        end else if (setup) begin
            o_prdata <= rd_val;
            err_r    <= !rd_ok;
        end
    end

    // Configuration writes
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            for (int i = 0; i < NCH; i++) begin
                sp1_r[i]   <= RST_SP;
                sp2_r[i]   <= RST_SP;
                hysteresis_half_width_r[i]  <= RST_HYSTERESIS_HALF_WIDTH;
                mode_r[i]  <= MODE_INACTIVE;
                react_r[i] <= REACT_HOLD;
                don_r[i]   <= RST_DLY;
                doff_r[i]  <= RST_DLY;
            end
            unit_r       <= '0;
            beeper_menu_en_r    <= '0;
            cmd_r        <= '0;
            beeper_menu_alarm_r <= 1'b0;
            timeout_r    <= RST_TO;
        end else if (wr && ch_ok) begin
            unique case (off)
                A_SP1:  sp1_r[ch]  <= i_pwdata[SPW-1:0];
                A_SP2:  sp2_r[ch]  <= i_pwdata[SPW-1:0];
                A_HYSTERESIS_HALF_WIDTH: hysteresis_half_width_r[ch] <= i_pwdata[HYW-1:0];
                A_CFG: begin
                    mode_r[ch]    <= mode_t'(i_pwdata[CFG_MODE+:3]);
                    react_r[ch]   <= react_t'(i_pwdata[CFG_REACT+:2]);
                    unit_r[ch]    <= i_pwdata[CFG_UNIT];
                    beeper_menu_en_r[ch] <= i_pwdata[CFG_BEEPER_MENU];
                end
                A_DLY: begin
                    don_r[ch]  <= i_pwdata[DLY_ON+:DLW];
                    doff_r[ch] <= i_pwdata[DLY_OFF+:DLW];
                end
                // remote command, cleared only by a write of 0 or by reset
                default: cmd_r[ch] <= i_pwdata[0];
            endcase
        end else if (wr && i_paddr == A_CTRL) begin
            beeper_menu_alarm_r <= i_pwdata[0];
        end else if (wr && i_paddr == A_SILENT) begin
            timeout_r <= i_pwdata[TOW-1:0];
        end
    end

    // ***************************
    // Time base
    // ***************************
    // tenth second tick
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            tick_cnt_r <= 24'h0;
            min_cnt_r  <= 6'h0;
        end else if (tick) begin
            tick_cnt_r <= 24'h0;
            min_cnt_r  <= tick_min ? 6'h0 : min_cnt_r + 6'h1;
        end else begin
            tick_cnt_r <= tick_cnt_r + 24'h1;
        end
    end
    assign tick     = (tick_cnt_r == 24'(TICK_CYCLES - 1));
    assign tick_min = tick && (min_cnt_r == 6'(MIN_SCALE - 1));

    // Bus silence: saturating, restarted by every remote command write
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            sil_cnt_r <= 16'h0;
        end else if (remote_wr) begin
            sil_cnt_r <= 16'h0;
        end else if (tick && sil_cnt_r != 16'hffff) begin
            sil_cnt_r <= sil_cnt_r + 16'h1;
        end
    end
    // A zero timeout disables silence detection
    assign silent = (timeout_r != 16'h0) && (sil_cnt_r >= timeout_r);

    // ***************************
    // Comparison
    // ***************************
    always_comb begin
        logic signed [CW-1:0] x, a, b, h, hi, lo;
        {a, b, h, hi, lo} = '0;
        x = sx(i_sample);
        for (int i = 0; i < NCH; i++) begin
            a = sx(sp1_r[i]);
            b = sx(sp2_r[i]);
            h = hx(hysteresis_half_width_r[i]);
            hi = (a > b) ? a : b;
            lo = (a > b) ? b : a;
            want_nxt[i] = want_r[i];
            // silence in remote, over range otherwise
            crit[i] = (mode_r[i] == MODE_REMOTE) ? silent : i_over_range;
            unique case (mode_r[i])
                MODE_INACTIVE: want_nxt[i] = 1'b0;
                MODE_ON: begin
                    if (x > a + h) want_nxt[i] = 1'b1;
                    else if (x < a - h) want_nxt[i] = 1'b0;
                end
                MODE_OFF: begin
                    if (x > a + h) want_nxt[i] = 1'b0;
                    else if (x < a - h) want_nxt[i] = 1'b1;
                end
                MODE_IN: begin
                    if (x > lo + h && x < hi - h) want_nxt[i] = 1'b1;
                    else if (x > hi + h || x < lo - h) want_nxt[i] = 1'b0;
                end
                MODE_OUT: begin
                    if (x > hi + h || x < lo - h) want_nxt[i] = 1'b1;
                    else if (x > lo + h && x < hi - h) want_nxt[i] = 1'b0;
                end
                MODE_REMOTE: want_nxt[i] = cmd_r[i];
                default: want_nxt[i] = 1'b0;
            endcase
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            want_r <= '0;
        end else begin
            for (int i = 0; i < NCH; i++)
                if (i_sample_valid || mode_r[i] == MODE_REMOTE || mode_r[i] == MODE_INACTIVE)
                    want_r[i] <= want_nxt[i];
        end
    end

    // ***************************
    // Delays and outputs
    // ***************************
    // Delay counts whole ticks, so a change may come up to one tick early
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            relay_r <= '0;
            for (int i = 0; i < NCH; i++)
                cnt_r[i] <= RST_DLY;
        end else begin
            for (int i = 0; i < NCH; i++) begin
                if (crit[i]) begin
                    cnt_r[i] <= RST_DLY;
                end else if (mode_r[i] == MODE_INACTIVE) begin
                    relay_r[i] <= 1'b0;
                    cnt_r[i]   <= RST_DLY;
                end else if (want_r[i] == relay_r[i]) begin
                    cnt_r[i] <= RST_DLY;
                end else if (cnt_r[i] >= (want_r[i] ? don_r[i] : doff_r[i])) begin
                    relay_r[i] <= want_r[i];
                    cnt_r[i]   <= RST_DLY;
                end else if (unit_r[i] ? tick_min : tick) begin
                    cnt_r[i] <= cnt_r[i] + 10'h1;
                end
            end
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            out_r <= '0;
        end else begin
            for (int i = 0; i < NCH; i++) begin
                if (!crit[i])                      out_r[i] <= relay_r[i];
                else if (react_r[i] == REACT_ON)  out_r[i] <= 1'b1;
                else if (react_r[i] == REACT_OFF) out_r[i] <= 1'b0;
            end
        end
    end
    assign o_relay = out_r;
    assign o_led   = out_r;

    // ***************************
    // Beeper
    // ***************************
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            btn_s1_r <= 1'b0;
            btn_s2_r <= 1'b0;
            btn_s3_r <= 1'b0;
        end else begin
            btn_s1_r <= i_button;
            btn_s2_r <= btn_s1_r;
            btn_s3_r <= btn_s2_r;
        end
    end
    assign press = btn_s2_r && !btn_s3_r;

    assign beeper_menu_set = (beeper_menu_alarm_r && (|crit) && !crit_any_r) || (|(out_r & ~out_d_r & beeper_menu_en_r));

    // A new event wins over a press in the same cycle
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            beeper_menu_r     <= 1'b0;
            crit_any_r <= 1'b0;
            out_d_r    <= '0;
        end else begin
            crit_any_r <= |crit;
            out_d_r    <= out_r;
            if (beeper_menu_set)   beeper_menu_r <= 1'b1;
            else if (press) beeper_menu_r <= 1'b0;
        end
    end
    assign o_buzzer = beeper_menu_r;

    // ***************************
    // Assertions
    // ***************************
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_b);
    a_button_silence: assert property (press && !beeper_menu_set |=> !o_buzzer)
        else $error("buzzer not silenced by button");
    a_alarm_beeper_menu: assert property (beeper_menu_alarm_r && (|crit) && !crit_any_r |=> o_buzzer)
        else $error("critical did not sound buzzer");
    for (genvar g = 0; g < NCH; g++) begin : g_chk
        sequence s_idle;
            mode_r[g] == MODE_INACTIVE && !crit[g];
        endsequence
        a_inactive_off: assert property (s_idle ##1 s_idle |=> !o_relay[g])
            else $error("inactive relay energised");
        a_normal_on: assert property (i_sample_valid && mode_r[g] == MODE_ON &&
            sx(i_sample) > sx(sp1_r[g]) + hx(hysteresis_half_width_r[g]) |=> want_r[g])
            else $error("normal mode missed upper border");
        a_inverted_off: assert property (i_sample_valid && mode_r[g] == MODE_OFF &&
            sx(i_sample) > sx(sp1_r[g]) + hx(hysteresis_half_width_r[g]) |=> !want_r[g])
            else $error("inverted mode missed upper border");
        a_delay_full: assert property (!crit[g] && $changed(relay_r[g]) && $past(mode_r[g]) != MODE_INACTIVE
            |-> $past(cnt_r[g]) >= (relay_r[g] ? $past(don_r[g]) : $past(doff_r[g])))
            else $error("relay changed before delay elapsed");
        a_delay_restart: assert property (want_r[g] == relay_r[g] && !crit[g] |=> cnt_r[g] == 10'h0)
            else $error("delay not restarted");
        a_force_on: assert property (crit[g] && react_r[g] == REACT_ON |=> o_relay[g])
            else $error("force on not applied");
        a_force_off: assert property (crit[g] && react_r[g] == REACT_OFF |=> !o_relay[g])
            else $error("force off not applied");
        a_range_crit: assert property (mode_r[g] == MODE_ON && i_over_range |-> crit[g])
            else $error("over range not critical");
        a_silence_crit: assert property (mode_r[g] == MODE_REMOTE && silent |-> crit[g])
            else $error("bus silence not critical");
        a_remote_follow: assert property (mode_r[g] == MODE_REMOTE |=> want_r[g] == $past(cmd_r[g]))
            else $error("remote state not followed");
    end
endmodule // relay_threshold_controller
`default_nettype wire

// ==== bench/meas_feed.sv ====
`timescale 1ns/100ps
`default_nettype none
module meas_feed
    import relay_pkg::*;
#(
    parameter int NCH = 4                          // Channels watched
) (
    input  wire logic                  i_clk,      // System clock
    input  wire logic                  i_go,       // Bench asks for a sample
    input  wire logic signed [SPW-1:0] i_val,      // Value to present
    input  wire logic [NCH-1:0]        i_relay,    // Relay coils seen
    input  wire logic [NCH-1:0]        i_led,      // LEDs seen
    output logic                       o_valid,    // Sample strobe
    output logic signed [SPW-1:0]      o_sample,   // Sample bus
    output logic                       o_led_bad   // Sticky LED and coil disagreement
);
    initial begin
        o_valid   = 1'b0;
        o_sample  = '0;
        o_led_bad = 1'b0;
    end

    always @(posedge i_clk) begin
        o_valid <= i_go;
        // Bus means nothing without the strobe, so it is scrambled then
        o_sample <= i_go ? i_val : ~o_sample;
        if (i_led !== i_relay) begin
            o_led_bad <= 1'b1;
        end
    end
endmodule // meas_feed
`default_nettype wire

// ==== bench/relay_threshold_controller_bench.sv ====
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, w) begin n_checks++; if ((g) !== (w)) begin mismatches++; $display("MISMATCH t=%0t got %0h want %0h", $time, g, w); end end
module relay_threshold_controller_bench;
    import relay_pkg::*;
    logic                  i_clk, i_rst_b, psel, penable, pwrite, go, over, button;
    logic                  pready, pslverr, e, valid, led_bad, buzzer;
    logic [8:0]            paddr;
    logic [31:0]           pwdata, prdata, q;
    logic signed [SPW-1:0] val, sample;
    logic [3:0]            relay, led;
    integer                mismatches = 0, n_checks = 0, seed = 21, x, st;

    relay_threshold_controller #(.NCH(4), .TICK_CYCLES(10)) i_relay_threshold_controller (
        .i_clk(i_clk), .i_rst_b(i_rst_b), .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite),
        .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
        .i_sample_valid(valid), .i_sample(sample), .i_over_range(over), .i_button(button),
        .o_relay(relay), .o_led(led), .o_buzzer(buzzer));
    meas_feed #(.NCH(4)) i_meas_feed (.i_clk(i_clk), .i_go(go), .i_val(val), .i_relay(relay),
        .i_led(led), .o_valid(valid), .o_sample(sample), .o_led_bad(led_bad));

    // ***************************
    // Bus cycles and model
    // ***************************
    task final_report;
        if (mismatches == 0 && n_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask

    task apb(input logic w, input logic [8:0] a, input logic [31:0] d);
        int n;
        @(posedge i_clk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge i_clk);
        penable <= 1'b1;
        n = 0;
        do begin @(posedge i_clk); n++; end while (pready !== 1'b1 && n < 16);
        q = prdata;
        e = pslverr;
        if (n == 16) begin mismatches++; final_report; end
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task wr(input logic [8:0] a, input logic [31:0] d); apb(1'b1, a, d); endtask
    task rd(input logic [8:0] a); apb(1'b0, a, 32'h0); endtask
    function logic [8:0] ca(input logic [1:0] c, input logic [4:0] off); return {2'b00, c, off}; endfunction

    task smp(input int v, input int w);
        @(posedge i_clk); go <= 1'b1; val <= SPW'(v);
        @(posedge i_clk); go <= 1'b0;
        repeat (w) @(posedge i_clk);
    endtask

    // Borders are strict: a value on a border keeps the state
    function int want(int md, int s1, int s2, int h, int v, int p);
        int lo, hi;
        lo = s1 < s2 ? s1 : s2;
        hi = s1 < s2 ? s2 : s1;
        case (md)
            1: return v > s1 + h ? 1 : v < s1 - h ? 0 : p;
            2: return v > s1 + h ? 0 : v < s1 - h ? 1 : p;
            3: return (v > lo + h && v < hi - h) ? 1 : (v < lo - h || v > hi + h) ? 0 : p;
            4: return (v > hi + h || v < lo - h) ? 1 : (v > lo + h && v < hi - h) ? 0 : p;
            default: return 0;
        endcase
    endfunction

    // ***************************
    // Sequence
    // ***************************
    initial begin
        i_clk = 1'b0;
        forever #5 i_clk = ~i_clk;
    end

    initial begin
        i_rst_b = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 9'h000;
        pwdata = 32'h0; go = 1'b0; val = '0; over = 1'b0; button = 1'b0;
        repeat (8) @(posedge i_clk);
        i_rst_b <= 1'b1;
        for (int c = 0; c < 4; c++) begin
            for (int o = 0; o < 6; o++) begin
                rd(ca(2'(c), 5'(o * 4))); `CHK(q, 32'h0)
            end
        end
        rd(9'h018); `CHK(e, 1'b1)
        wr(ca(2'd3, A_SP1), 32'(-99999)); rd(ca(2'd3, A_SP1)); `CHK(q, 32'(-99999))
        wr(ca(2'd3, A_SP2), 32'd999999); rd(ca(2'd3, A_SP2)); `CHK(q, 32'd999999)
        wr(ca(2'd3, A_HYSTERESIS_HALF_WIDTH), 32'd99999); rd(ca(2'd3, A_HYSTERESIS_HALF_WIDTH)); `CHK(q, 32'd99999)
        wr(ca(2'd0, A_SP1), 32'd100); wr(ca(2'd0, A_SP2), 32'(-50)); wr(ca(2'd0, A_HYSTERESIS_HALF_WIDTH), 32'd10);
        for (int md = 1; md < 5; md++) begin
            wr(ca(2'd0, A_CFG), 32'h0); wr(ca(2'd0, A_CFG), 32'(md)); st = 0;
            repeat (14) begin
                x = $random(seed) % 300;
                smp(x, 5); st = want(md, 100, -50, 10, x, st);
                `CHK(relay[0], st[0])
            end
        end
        wr(ca(2'd0, A_CFG), 32'h0); smp(500, 5); `CHK(relay[0], 1'b0)
        // Delays on channel 1: on 3 tenths, a glitch shorter than that first
        wr(ca(2'd1, A_SP1), 32'd100); wr(ca(2'd1, A_CFG), 32'h1); wr(ca(2'd1, A_DLY), 32'h3);
        smp(500, 12); `CHK(relay[1], 1'b0)
        smp(-500, 40); `CHK(relay[1], 1'b0)
        smp(500, 45); `CHK(relay[1], 1'b1)
        wr(ca(2'd1, A_DLY), 32'h0004_0003);
        smp(-500, 20); `CHK(relay[1], 1'b1)
        repeat (30) @(posedge i_clk); `CHK(relay[1], 1'b0)
        wr(ca(2'd1, A_CFG), 32'h21); wr(ca(2'd1, A_DLY), 32'h2);
        smp(500, 500); `CHK(relay[1], 1'b0)
        repeat (800) @(posedge i_clk); `CHK(relay[1], 1'b1)
        // Alarm reactions: hold on 0, force off on 1, force on over inactive 2
        wr(ca(2'd0, A_CFG), 32'h1); smp(500, 5); wr(ca(2'd1, A_CFG), 32'h31);
        wr(ca(2'd2, A_CFG), 32'h8); wr(A_CTRL, 32'h1);
        over <= 1'b1;
        smp(-500, 5); `CHK(relay, 4'b0101)
        `CHK(buzzer, 1'b1)
        button <= 1'b1; repeat (6) @(posedge i_clk); `CHK(buzzer, 1'b0)
        button <= 1'b0; over <= 1'b0; wr(A_CTRL, 32'h0); wr(ca(2'd0, A_CFG), 32'h41);
        smp(-500, 5); smp(500, 6); `CHK(buzzer, 1'b1)
        button <= 1'b1; repeat (6) @(posedge i_clk); `CHK(buzzer, 1'b0)
        button <= 1'b0;
        // Remote channel 3, silence limit 3 tenths forces off
        wr(ca(2'd3, A_CFG), 32'h15); wr(A_SILENT, 32'h3); wr(ca(2'd3, A_REMOTE), 32'h1);
        smp(-500, 2); `CHK(relay[3], 1'b1)
        repeat (60) @(posedge i_clk); `CHK(relay[3], 1'b0)
        rd(ca(2'd3, A_REMOTE)); `CHK(q, 32'h1)
        // Restart in mid-run: the remote command must not survive it
        i_rst_b <= 1'b0;
        repeat (2) @(posedge i_clk);
        i_rst_b <= 1'b1;
        `CHK(relay, 4'b0000)
        rd(ca(2'd3, A_REMOTE)); `CHK(q, 32'h0)
        `CHK(led_bad, 1'b0)
        final_report;
    end
endmodule // relay_threshold_controller_bench
`default_nettype wire
